// File: common/lps_map.svh
// Constants of the low-power entry and exit sequencer.
// Assumes a single 250 MHz core clock domain.
`ifndef LPS_MAP_SVH
`define LPS_MAP_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define LPS_DLY_W   21
`define LPS_ST_W    5
`define LPS_CPU_W   2
`define LPS_SYS_W   3

// ****************************************************************
// Timing
// ****************************************************************
`define LPS_CLK_PERIOD_NS 4
`define LPS_SYNC_STAGES   2

`endif

// File: common/lps_pkg.sv
// Types of the low-power entry and exit sequencer.
// Assumes lps_map.svh is on the include path.
`include "lps_map.svh"

package lps_pkg;

  // ****************************************************************
  // Sequencer states, one-hot
  // ****************************************************************
  typedef enum logic [`LPS_ST_W-1:0] {
    ST_RUN     = 5'h01,
    ST_CPU_LP  = 5'h02,
    ST_SYS_LP  = 5'h04,
    ST_RESTORE = 5'h08,
    ST_RECOVER = 5'h10
  } lps_state_t;

  // ****************************************************************
  // Subsystem and system low-power modes
  // ****************************************************************
  typedef enum logic [`LPS_CPU_W-1:0] {
    CPU_RUN     = 2'h0,
    CPU_SLEEP   = 2'h1,
    CPU_STOP    = 2'h2,
    CPU_STANDBY = 2'h3
  } lps_cpu_mode_t;

  typedef enum logic [`LPS_SYS_W-1:0] {
    SYS_RUN            = 3'h0,
    SYS_STOP           = 3'h1,
    SYS_LOW_POWER_STOP = 3'h2,
    SYS_LOW_VOLT_STOP  = 3'h3,
    SYS_CORE_OFF_STOP  = 3'h4,
    SYS_STANDBY        = 3'h5
  } lps_sys_mode_t;

  // Settings held by the clock and power control registers
  typedef struct packed {
    lps_cpu_mode_t         cpu_mode;
    lps_sys_mode_t         sys_mode;
    logic                  supply_pin_config;
    logic                  ddr_retention_enable;
    logic                  ddr_io_supply_on;
    logic [`LPS_DLY_W-1:0] recovery_delay;
  } lps_cfg_t;

endpackage

// File: src/lps_sequencer.sv
// Low-power mode entry and exit sequencer.
// Assumes cfg_i, wfi_i and ddr_self_refresh_i come from logic on core_clk_i;
// wakeup_pending_i comes from another domain and is synchronised here.
`timescale 1ns/1ps
`include "lps_map.svh"

module lps_sequencer
  import lps_pkg::*;
(
  input  wire logic                  core_clk_i,
  input  wire logic                  device_reset_input_i,
  input  wire lps_cfg_t              cfg_i,
  input  wire logic                  wfi_i,
  input  wire logic                  wakeup_pending_i,
  input  wire logic                  ddr_self_refresh_i,
  output logic                       run_o,
  output lps_cpu_mode_t              cpu_state_o,
  output lps_sys_mode_t              sys_state_o,
  output logic                       supply_on_out_o,
  output logic                       supply_lowpower_out_o,
  output logic                       ddr_phy_retention_o,
  output logic                       pll_restore_o
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic is_retention_mode(input lps_sys_mode_t m);
    return (m == SYS_LOW_VOLT_STOP) || (m == SYS_CORE_OFF_STOP);
  endfunction

  // ****************************************************************
  // Wake-up synchroniser
  // ****************************************************************
  logic wake_meta;
  logic wake;

  always_ff @(posedge core_clk_i or negedge device_reset_input_i) begin
    if (!device_reset_input_i) begin
      wake_meta <= 1'h0;
      wake      <= 1'h0;
    end else begin
      wake_meta <= wakeup_pending_i;
      wake      <= wake_meta;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  lps_state_t            state;
  lps_state_t            next_state;
  lps_cpu_mode_t         cpu_mode;
  lps_cpu_mode_t         next_cpu_mode;
  lps_sys_mode_t         sys_mode;
  lps_sys_mode_t         next_sys_mode;
  logic [`LPS_DLY_W-1:0] dly_cnt;
  logic                  ddr_ok;
  logic                  sys_entry;

  assign ddr_ok = !is_retention_mode(cfg_i.sys_mode) || !cfg_i.ddr_io_supply_on
                  || (ddr_self_refresh_i && cfg_i.ddr_retention_enable);
  assign sys_entry = ((cpu_mode == CPU_STOP) || (cpu_mode == CPU_STANDBY))
                     && !wake && (cfg_i.sys_mode != SYS_RUN) && ddr_ok;

  always_comb begin
    next_state    = state;
    next_cpu_mode = cpu_mode;
    next_sys_mode = sys_mode;
    case (state)
      ST_RUN: begin
        if (wfi_i && (cfg_i.cpu_mode != CPU_RUN)) begin
          next_state    = ST_CPU_LP;
          next_cpu_mode = cfg_i.cpu_mode;
        end
      end
      ST_CPU_LP: begin
        if (wake) begin
          next_state    = ST_RUN;
          next_cpu_mode = CPU_RUN;
        end else if (sys_entry) begin
          next_state    = ST_SYS_LP;
          next_sys_mode = cfg_i.sys_mode;
        end
      end
      ST_SYS_LP: begin
        if (wake) begin
          next_state = ST_RESTORE;
        end
      end
      ST_RESTORE: begin
        // Plain stop goes straight back to Run
        if (sys_mode == SYS_STOP || dly_cnt == '0) begin
          next_state    = ST_RUN;
          next_cpu_mode = CPU_RUN;
          next_sys_mode = SYS_RUN;
        end else begin
          next_state = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        if (dly_cnt == `LPS_DLY_W'(1)) begin
          next_state    = ST_RUN;
          next_cpu_mode = CPU_RUN;
          next_sys_mode = SYS_RUN;
        end
      end
      default: begin
        next_state    = ST_RUN;
        next_cpu_mode = CPU_RUN;
        next_sys_mode = SYS_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge device_reset_input_i) begin
    if (!device_reset_input_i) begin
      state    <= ST_RUN;
      cpu_mode <= CPU_RUN;
      sys_mode <= SYS_RUN;
    end else begin
      state    <= next_state;
      cpu_mode <= next_cpu_mode;
      sys_mode <= next_sys_mode;
    end
  end

  // ****************************************************************
  // Recovery delay counter
  // ****************************************************************
  always_ff @(posedge core_clk_i or negedge device_reset_input_i) begin
    if (!device_reset_input_i) begin
      dly_cnt <= '0;
    end else if (state == ST_SYS_LP && wake) begin
      dly_cnt <= cfg_i.recovery_delay;
    end else if (state == ST_RECOVER && dly_cnt != '0) begin
      dly_cnt <= dly_cnt - `LPS_DLY_W'(1);
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  logic next_low;
  logic next_standby;

  assign next_low     = (next_state == ST_SYS_LP) && (next_sys_mode != SYS_STOP);
  assign next_standby = (next_state == ST_SYS_LP) && (next_sys_mode == SYS_STANDBY);

  always_ff @(posedge core_clk_i or negedge device_reset_input_i) begin
    if (!device_reset_input_i) begin
      run_o                 <= 1'h1;
      cpu_state_o           <= CPU_RUN;
      sys_state_o           <= SYS_RUN;
      supply_on_out_o       <= 1'h1;
      supply_lowpower_out_o <= 1'h1;
      ddr_phy_retention_o   <= 1'h0;
      pll_restore_o         <= 1'h0;
    end else begin
      run_o                 <= (next_state == ST_RUN);
      cpu_state_o           <= next_cpu_mode;
      sys_state_o           <= next_sys_mode;
      // Back to one as soon as the wake-up leaves the low state
      supply_on_out_o       <= cfg_i.supply_pin_config ? !next_low : !next_standby;
      supply_lowpower_out_o <= !next_low;
      ddr_phy_retention_o   <= (next_state == ST_SYS_LP) && is_retention_mode(next_sys_mode)
                               && cfg_i.ddr_retention_enable;
      pll_restore_o         <= (next_state == ST_RESTORE);
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!device_reset_input_i);

  AST_WFI_ENTRY: assert property (
    (state == ST_RUN && wfi_i && cfg_i.cpu_mode != CPU_RUN)
      |=> (state == ST_CPU_LP && cpu_state_o == $past(cfg_i.cpu_mode) && !run_o))
    else $error("wait instruction did not enter subsystem low power");

  AST_SYS_ENTRY_GUARD: assert property (
    (sys_state_o != SYS_RUN && $past(sys_state_o) == SYS_RUN)
      |-> (!$past(wake) && $past(cpu_state_o) inside {CPU_STOP, CPU_STANDBY}))
    else $error("system low power entered with wake-up pending or core not stopped");

  AST_DDR_RETENTION: assert property (
    (sys_state_o inside {SYS_LOW_VOLT_STOP, SYS_CORE_OFF_STOP}
      && $past(sys_state_o) == SYS_RUN && $past(cfg_i.ddr_io_supply_on))
      |-> ($past(ddr_self_refresh_i) && ddr_phy_retention_o))
    else $error("retention stop entered without DDR self-refresh and retention");

  AST_PLL_RESTORE: assert property (
    (state == ST_SYS_LP && wake) |=> (pll_restore_o && state == ST_RESTORE))
    else $error("PLL restore not pulsed on stop exit");

  AST_STOP_FAST_EXIT: assert property (
    (state == ST_RESTORE && sys_mode == SYS_STOP) |=> (run_o && supply_on_out_o))
    else $error("plain stop exit did not return to run at once");

  AST_RECOVERY_WAIT: assert property (
    (state == ST_SYS_LP && wake && sys_mode != SYS_STOP && cfg_i.recovery_delay == 21'h000003)
      |=> !run_o [*4] ##1 run_o)
    else $error("recovery delay not honoured");

  AST_SUPPLY_WAKE: assert property (
    (state == ST_SYS_LP && sys_mode == SYS_LOW_POWER_STOP && wake) |=> supply_on_out_o)
    else $error("supply_on_out not raised on wake-up");

  AST_SUPPLY_PIN_LOW: assert property (
    (state == ST_SYS_LP && $stable(state) && cfg_i.supply_pin_config
      && sys_mode != SYS_STOP) |-> !supply_on_out_o)
    else $error("supply_on_out high in a deep state");

  AST_COUNT_DOWN: assert property (
    (state == ST_RECOVER && dly_cnt > 21'h000001) |=> (dly_cnt == $past(dly_cnt) - 21'h000001))
    else $error("recovery counter did not decrement");

  COV_SLEEP_WAKE: cover property (state == ST_CPU_LP && cpu_mode == CPU_SLEEP ##1 state == ST_RUN);
  COV_STOP_CYCLE: cover property (state == ST_SYS_LP && sys_mode == SYS_STOP ##[1:50] run_o);
  COV_LP_RECOVER: cover property (state == ST_RECOVER ##[1:200] run_o);
  COV_RETENTION:  cover property (ddr_phy_retention_o);

endmodule

// File: bench/lps_regulator_model.sv
// External supply regulator model facing the low-power sequencer.
// Assumes the sequencer's supply pins and a power-on reset from the bench.
`timescale 1ns/1ps

module lps_regulator_model #(
  parameter int RAMP = 1
) (
  input  wire logic core_clk_i,
  input  wire logic por_n_i,
  input  wire logic supply_on_i,
  input  wire logic supply_lp_i,
  output logic      supply_ok_o,
  output logic      device_reset_input_o
);
  int unsigned ramp;

  // ****
  // Supply ramp, restarted whenever a supply is lowered
  // ****
  always_ff @(posedge core_clk_i or negedge por_n_i) begin
    if (!por_n_i) begin
      ramp <= RAMP;
    end else if (!supply_on_i || !supply_lp_i) begin
      ramp <= RAMP;
    end else if (ramp != 0) begin
      ramp <= ramp - 1;
    end
  end

  assign supply_ok_o = (ramp == 0);

  // ****
  // Device reset held until supplies first settle
  // ****
  always_ff @(posedge core_clk_i or negedge por_n_i) begin
    if (!por_n_i) begin
      device_reset_input_o <= 1'h0;
    end else if (supply_ok_o) begin
      device_reset_input_o <= 1'h1;
    end
  end
endmodule

// File: bench/tb_lps_sequencer.sv
// Self-checking bench for the low-power entry and exit sequencer.
// Assumes the regulator model drives the device reset.
`timescale 1ns/1ps
`include "lps_map.svh"
`define CHK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin fails++; \
  $display("unexpected %s: expected %0h seen %0h", what, exp, got); end end

module tb_lps_sequencer
  import lps_pkg::*;
;
  logic          core_clk = 1'h0;
  logic          por_n    = 1'h0;
  logic          wfi      = 1'h0;
  logic          wake     = 1'h0;
  logic          sref     = 1'h0;
  lps_cfg_t      cfg      = '0;
  logic          device_reset_input;
  logic          run;
  logic          supply_on;
  logic          supply_lp;
  logic          ret;
  logic          pll;
  logic          supply_ok;
  lps_cpu_mode_t cpu_st;
  lps_sys_mode_t sys_st;
  int            fails        = 0;
  int            total_checks = 0;
  int            cyc          = 0;

  lps_sequencer dut (.core_clk_i(core_clk), .device_reset_input_i(device_reset_input), .cfg_i(cfg), .wfi_i(wfi),
    .wakeup_pending_i(wake), .ddr_self_refresh_i(sref), .run_o(run), .cpu_state_o(cpu_st),
    .sys_state_o(sys_st), .supply_on_out_o(supply_on), .supply_lowpower_out_o(supply_lp),
    .ddr_phy_retention_o(ret), .pll_restore_o(pll));

  lps_regulator_model #(.RAMP(1)) reg_model (.core_clk_i(core_clk), .por_n_i(por_n),
    .supply_on_i(supply_on), .supply_lp_i(supply_lp), .supply_ok_o(supply_ok), .device_reset_input_o(device_reset_input));

  initial begin
    forever #2 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      end_of_test();
    end
  end

  // ****
  // Shared tasks
  // ****
  task automatic end_of_test();
    if (fails == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic tick(int n = 1);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic enter(lps_cpu_mode_t c, lps_sys_mode_t s, logic pin, logic io,
                       logic [`LPS_DLY_W-1:0] d);
    cfg = '{c, s, pin, 1'h1, io, d};
    wfi = 1'h1;
    tick();
    `CHK("run_o", 1'h0, run)
    `CHK("cpu_state_o", c, cpu_st)
    wfi = 1'h0;
  endtask

  task automatic sys_enter(lps_cpu_mode_t c, lps_sys_mode_t s, logic pin, logic io,
                           logic [`LPS_DLY_W-1:0] d, logic eon, logic elp, logic eret);
    enter(c, s, pin, io, d);
    tick(2);
    `CHK("sys_state_o", s, sys_st)
    `CHK("supply_on_out_o", eon, supply_on)
    `CHK("supply_lowpower_out_o", elp, supply_lp)
    `CHK("ddr_phy_retention_o", eret, ret)
  endtask

  task automatic wake_up(int exp_n, logic sys_exit);
    int n;
    n = 0;
    wake = 1'h1;
    while (sys_exit && pll !== 1'h1 && n < 8) begin
      tick();
      n++;
    end
    if (sys_exit) begin
      `CHK("pll_restore_o", 1'h1, pll)
      `CHK("supply_on_out_o", 1'h1, supply_on)
      `CHK("ddr_phy_retention_o", 1'h0, ret)
      n = 0;
    end
    while (run !== 1'h1 && n < 20) begin
      tick();
      n++;
    end
    `CHK("run_o", 1'h1, run)
    if (sys_exit) begin
      `CHK("recovery cycles", exp_n, n)
    end
    `CHK("supply_ok", 1'h1, supply_ok)
    wake = 1'h0;
    tick(4);
  endtask

  // ****
  // Scenarios
  // ****
  task automatic reset_release();
    tick(3);
    `CHK("reset run_o", 1'h1, run)
    `CHK("reset supply_on_out_o", 1'h1, supply_on)
    `CHK("reset sys_state_o", SYS_RUN, sys_st)
    por_n = 1'h1;
    tick(5);
  endtask

  task automatic sleep_never_enters_system();
    enter(CPU_SLEEP, SYS_STOP, 1'h1, 1'h0, 21'h5);
    tick(3);
    `CHK("sleep sys_state_o", SYS_RUN, sys_st)
    wake_up(0, 1'h0);
  endtask

  // Wake-up already pending: the core drops back to Run, no system entry
  task automatic pending_wake_blocks_entry();
    wake = 1'h1;
    tick(4);
    enter(CPU_STOP, SYS_STOP, 1'h1, 1'h0, 21'h5);
    tick(4);
    `CHK("pending sys_state_o", SYS_RUN, sys_st)
    wake_up(0, 1'h0);
  endtask

  task automatic stop_exit();
    sys_enter(CPU_STOP, SYS_STOP, 1'h1, 1'h0, 21'h5, 1'h1, 1'h1, 1'h0);
    wake_up(1, 1'h1);
  endtask

  // Delay is scaled down from the recommended value to keep the run short
  task automatic low_power_stop_exit();
    sys_enter(CPU_STOP, SYS_LOW_POWER_STOP, 1'h1, 1'h0, 21'h3, 1'h0, 1'h0, 1'h0);
    wake_up(4, 1'h1);
  endtask

  task automatic deep_stop_exits();
    sys_enter(CPU_STANDBY, SYS_CORE_OFF_STOP, 1'h0, 1'h0, 21'h2, 1'h1, 1'h0, 1'h1);
    wake_up(3, 1'h1);
    sys_enter(CPU_STANDBY, SYS_STANDBY, 1'h0, 1'h0, 21'h0, 1'h0, 1'h0, 1'h0);
    wake_up(1, 1'h1);
  endtask

  task automatic ddr_retention_entry();
    enter(CPU_STOP, SYS_LOW_VOLT_STOP, 1'h1, 1'h1, 21'h3);
    tick(4);
    `CHK("no self-refresh sys_state_o", SYS_RUN, sys_st)
    sref = 1'h1;
    tick(3);
    `CHK("sys_state_o", SYS_LOW_VOLT_STOP, sys_st)
    `CHK("ddr_phy_retention_o", 1'h1, ret)
    wake_up(4, 1'h1);
  endtask

  initial begin
    reset_release();
    sleep_never_enters_system();
    pending_wake_blocks_entry();
    stop_exit();
    low_power_stop_exit();
    deep_stop_exits();
    ddr_retention_entry();
    end_of_test();
  end
endmodule
